// file: inc/ctr_pkg.sv
// Package with the constants and types of the converter trim register bank.
package ctr_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned CTR_ADDR_W = 12;
    localparam int unsigned CTR_DATA_W = 32;
    localparam int unsigned CTR_IDX_W = 10;
    localparam int unsigned CTR_NUM_OFS = 4;
    localparam int unsigned CTR_NUM_GAIN = 4;
    localparam int unsigned CTR_NUM_TRIM = 8;
    localparam int unsigned CTR_FUSE_AW = 3;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [9:0] CTR_IDX_OFFSET_TRIM_CORE3_THIRD_INPUT = 10'h338;
    localparam logic [9:0] CTR_IDX_OFFSET_TRIM_CORE3_FOURTH_INPUT = 10'h33A;
    localparam logic [9:0] CTR_IDX_OFFSET_TRIM_CORE4 = 10'h33C;
    localparam logic [9:0] CTR_IDX_OFFSET_TRIM_CORE5 = 10'h33E;
    localparam logic [9:0] CTR_IDX_FINE_GAIN_TRIM_CORE0 = 10'h360;
    localparam logic [9:0] CTR_IDX_FINE_GAIN_TRIM_CORE1 = 10'h361;
    localparam logic [9:0] CTR_IDX_FINE_GAIN_TRIM_CORE2_FIRST_INPUT = 10'h362;
    localparam logic [9:0] CTR_IDX_FINE_GAIN_TRIM_CORE2_SECOND_INPUT = 10'h363;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CTR_OFS_W = 16;
    localparam int unsigned CTR_OFS_VAL_W = 12;
    localparam int unsigned CTR_OFS_RSV_LSB = 12;
    localparam int unsigned CTR_GAIN_W = 8;
    localparam int unsigned CTR_GAIN_VAL_W = 5;
    localparam int unsigned CTR_GAIN_RSV_LSB = 5;
    localparam logic [15:0] CTR_OFS_RESET = 16'h0000;
    localparam logic [7:0] CTR_GAIN_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ctr_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctr_apb_rsp_t;

    typedef struct packed {
        logic [11:0] offsetCore3;
        logic [11:0] offsetCore4;
        logic [11:0] offsetCore5;
        logic [4:0] gainCore0;
        logic [4:0] gainCore1;
        logic [4:0] gainCore2;
    } ctr_trim_out_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] data;
    } ctr_fuse_wr_t;

    typedef struct packed {
        logic isOfs;
        logic isGain;
        logic [1:0] sel;
    } ctr_dec_t;

    typedef enum logic [1:0] {LDR_READ, LDR_DRAIN, LDR_DONE} ctr_ldr_phase_t;

    typedef struct packed {
        ctr_ldr_phase_t phase;
        logic [2:0] addr;
        logic [2:0] prevAddr;
        ctr_fuse_wr_t wr;
        logic done;
    } ctr_ldr_state_t;

    typedef struct packed {
        logic [3:0][15:0] ofs;
        logic [3:0][7:0] gain;
        logic [31:0] rdata;
        logic slverr;
        logic loaded;
        ctr_trim_out_t trim;
    } ctr_bank_state_t;

endpackage : ctr_pkg

// file: design/ctr_fuse_loader.sv
// Sequencer that copies the factory fuse words into the trim bank after reset.
`timescale 1ns/10ps
module ctr_fuse_loader #(
    parameter int unsigned NUM_WORDS = 8,
    parameter int unsigned ADDR_W = 3
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    output logic fuseRdEn,
    output logic [2:0] fuseAddr,
    input wire logic [15:0] fuseData,
    output ctr_pkg::ctr_fuse_wr_t fuseWr,
    output logic loadDone
);
    import ctr_pkg::*;

    if (NUM_WORDS < 2 || NUM_WORDS > (1 << ADDR_W) || ADDR_W != CTR_FUSE_AW)
    begin : g_bad_param
        $error("Fuse loader geometry not supported.");
    end

    localparam logic [2:0] LAST_ADDR = 3'(NUM_WORDS - 1);

    ctr_ldr_state_t st;
    ctr_ldr_state_t nxt_st;

    // ----------------------------------------------------------------
    // Read sequence: the fuse array answers one cycle after a read
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st;
        nxt_st.wr.valid = 1'b0;
        unique case (st.phase)
            LDR_READ:
            begin
                if (st.addr != 3'h0)
                begin
                    nxt_st.wr.valid = 1'b1;
                    nxt_st.wr.idx = st.prevAddr;
                    nxt_st.wr.data = fuseData;
                end
                nxt_st.prevAddr = st.addr;
                if (st.addr == LAST_ADDR)
                begin
                    nxt_st.phase = LDR_DRAIN;
                end
                else
                begin
                    nxt_st.addr = st.addr + 3'h1;
                end
            end
            LDR_DRAIN:
            begin
                nxt_st.wr.valid = 1'b1;
                nxt_st.wr.idx = st.prevAddr;
                nxt_st.wr.data = fuseData;
                nxt_st.phase = LDR_DONE;
                nxt_st.done = 1'b1;
            end
            LDR_DONE:
            begin
                nxt_st.done = 1'b1;
            end
            default:
            begin
                nxt_st.phase = LDR_DONE;
                nxt_st.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '{phase: LDR_READ, addr: 3'h0, prevAddr: 3'h0,
                    wr: '{valid: 1'b0, idx: 3'h0, data: 16'h0000}, done: 1'b0};
        end
        else
        begin
            st <= nxt_st;
        end
    end

    assign fuseRdEn = (st.phase == LDR_READ);
    assign fuseAddr = st.addr;
    assign fuseWr = st.wr;
    assign loadDone = st.done;

endmodule : ctr_fuse_loader

// file: design/ctr_trim_bank.sv
// Offset and fine gain trim register bank for the converter cores, with APB access.
//
// Functional notes
// - Offset trims keep a 12-bit value in bits 11:0, applied to cores 3, 4, 5.
// - Core 3 uses one offset for third input pair, another for fourth.
// - Gain trims keep a 5-bit value in bits 4:0, applied to its core gain.
// - Core 2 uses one gain for first input pair, another for second.
// - All trims load their power-up value from fuse storage; reset value zero.
// - Offsets are 16-bit at even addresses, gains 8-bit at consecutive addresses.
// - Offset trim values are treated as unsigned numbers.
`timescale 1ns/10ps
module ctr_trim_bank (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ctr_pkg::ctr_apb_req_t apbReq,
    output ctr_pkg::ctr_apb_rsp_t apbRsp,
    input wire logic core3SampleFourth,
    input wire logic core2SampleSecond,
    output logic fuseRdEn,
    output logic [2:0] fuseAddr,
    input wire logic [15:0] fuseData,
    output ctr_pkg::ctr_trim_out_t trimOut,
    output logic loadDone
);
    import ctr_pkg::*;

    ctr_bank_state_t st;
    ctr_bank_state_t nxt_st;
    ctr_fuse_wr_t fuseWr;
    logic ldrDone;
    logic accessWr;
    ctr_dec_t reqDec;
    logic [CTR_NUM_OFS-1:0] ofsHit;
    logic [CTR_NUM_GAIN-1:0] gainHit;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (CTR_NUM_OFS + CTR_NUM_GAIN != CTR_NUM_TRIM)
    begin : g_bad_count
        $error("Trim register count does not match the fuse word count.");
    end

    if (CTR_NUM_TRIM != (1 << CTR_FUSE_AW))
    begin : g_bad_fuse
        $error("Fuse address width does not cover the trim registers.");
    end

    if (CTR_FUSE_AW != 3)
    begin : g_bad_faw
        $error("Fuse address port is three bits wide.");
    end

    if (CTR_NUM_OFS != 4)
    begin : g_bad_ofs_num
        $error("Offset select field is two bits wide.");
    end

    if (CTR_NUM_GAIN != 4)
    begin : g_bad_gain_num
        $error("Gain select field is two bits wide.");
    end

    if (CTR_IDX_W + 2 != CTR_ADDR_W)
    begin : g_bad_addr
        $error("Address width must be the index width plus two.");
    end

    if (CTR_DATA_W != 32)
    begin : g_bad_data
        $error("Bus data width must be 32 bits.");
    end

    if (CTR_OFS_W != 16 || CTR_GAIN_W != 8)
    begin : g_bad_store
        $error("Register storage widths are fixed by the state struct.");
    end

    if (CTR_OFS_VAL_W > CTR_OFS_W)
    begin : g_bad_ofs_field
        $error("Offset value wider than its register.");
    end

    if (CTR_GAIN_VAL_W > CTR_GAIN_W)
    begin : g_bad_gain_field
        $error("Gain value wider than its register.");
    end

    if (CTR_OFS_RSV_LSB != CTR_OFS_VAL_W)
    begin : g_bad_ofs_rsv
        $error("Offset reserved field must sit right above the value.");
    end

    if (CTR_GAIN_RSV_LSB != CTR_GAIN_VAL_W)
    begin : g_bad_gain_rsv
        $error("Gain reserved field must sit right above the value.");
    end

    if (CTR_IDX_OFFSET_TRIM_CORE3_FOURTH_INPUT != CTR_IDX_OFFSET_TRIM_CORE3_THIRD_INPUT + 10'h002
        || CTR_IDX_OFFSET_TRIM_CORE4 != CTR_IDX_OFFSET_TRIM_CORE3_FOURTH_INPUT + 10'h002
        || CTR_IDX_OFFSET_TRIM_CORE5 != CTR_IDX_OFFSET_TRIM_CORE4 + 10'h002)
    begin : g_bad_ofs_map
        $error("Offset registers must sit at consecutive even locations.");
    end

    if (CTR_IDX_FINE_GAIN_TRIM_CORE1 != CTR_IDX_FINE_GAIN_TRIM_CORE0 + 10'h001
        || CTR_IDX_FINE_GAIN_TRIM_CORE2_FIRST_INPUT != CTR_IDX_FINE_GAIN_TRIM_CORE1 + 10'h001
        || CTR_IDX_FINE_GAIN_TRIM_CORE2_SECOND_INPUT != CTR_IDX_FINE_GAIN_TRIM_CORE2_FIRST_INPUT + 10'h001)
    begin : g_bad_gain_map
        $error("Gain registers must sit at consecutive locations.");
    end

    // ----------------------------------------------------------------
    // Address decoding
    // ----------------------------------------------------------------
    function automatic ctr_dec_t ctrDecode(input logic [11:0] addr);
        ctr_dec_t dec;
        logic [9:0] idx;
        dec = '{isOfs: 1'b0, isGain: 1'b0, sel: 2'h0};
        idx = addr[11:2];
        if (addr[1:0] == 2'h0)
        begin
            unique case (idx)
                CTR_IDX_OFFSET_TRIM_CORE3_THIRD_INPUT:
                    dec = '{isOfs: 1'b1, isGain: 1'b0, sel: 2'h0};
                CTR_IDX_OFFSET_TRIM_CORE3_FOURTH_INPUT:
                    dec = '{isOfs: 1'b1, isGain: 1'b0, sel: 2'h1};
                CTR_IDX_OFFSET_TRIM_CORE4:
                    dec = '{isOfs: 1'b1, isGain: 1'b0, sel: 2'h2};
                CTR_IDX_OFFSET_TRIM_CORE5:
                    dec = '{isOfs: 1'b1, isGain: 1'b0, sel: 2'h3};
                CTR_IDX_FINE_GAIN_TRIM_CORE0:
                    dec = '{isOfs: 1'b0, isGain: 1'b1, sel: 2'h0};
                CTR_IDX_FINE_GAIN_TRIM_CORE1:
                    dec = '{isOfs: 1'b0, isGain: 1'b1, sel: 2'h1};
                CTR_IDX_FINE_GAIN_TRIM_CORE2_FIRST_INPUT:
                    dec = '{isOfs: 1'b0, isGain: 1'b1, sel: 2'h2};
                CTR_IDX_FINE_GAIN_TRIM_CORE2_SECOND_INPUT:
                    dec = '{isOfs: 1'b0, isGain: 1'b1, sel: 2'h3};
                default:
                    dec = '{isOfs: 1'b0, isGain: 1'b0, sel: 2'h0};
            endcase
        end
        return dec;
    endfunction : ctrDecode

    function automatic logic [31:0] ctrReadWord(input ctr_dec_t dec,
                                                input logic [3:0][15:0] ofs,
                                                input logic [3:0][7:0] gain);
        logic [31:0] word;
        word = 32'h00000000;
        if (dec.isOfs)
        begin
            word = {16'h0000, ofs[dec.sel]};
        end
        else if (dec.isGain)
        begin
            word = {24'h000000, gain[dec.sel]};
        end
        return word;
    endfunction : ctrReadWord

    function automatic logic [15:0] ctrMergeOfs(input logic [15:0] old,
                                                input logic [31:0] wdata,
                                                input logic [3:0] strb);
        logic [15:0] word;
        word = old;
        for (int b = 0; b < 2; b++)
        begin
            if (strb[b])
            begin
                word[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return word;
    endfunction : ctrMergeOfs

    // ----------------------------------------------------------------
    // Fuse loading
    // ----------------------------------------------------------------
    ctr_fuse_loader #(
        .NUM_WORDS(CTR_NUM_TRIM),
        .ADDR_W(CTR_FUSE_AW)
    ) u_fuse_loader (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .fuseRdEn(fuseRdEn),
        .fuseAddr(fuseAddr),
        .fuseData(fuseData),
        .fuseWr(fuseWr),
        .loadDone(ldrDone)
    );

    // ----------------------------------------------------------------
    // Bus request qualification
    // ----------------------------------------------------------------
    assign reqDec = ctrDecode(apbReq.paddr);
    assign accessWr = apbReq.psel && apbReq.penable && apbReq.pwrite && st.loaded;

    // ----------------------------------------------------------------
    // Per-register write strobes
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CTR_NUM_OFS; i++)
    begin : g_ofs_hit
        assign ofsHit[i] = accessWr && reqDec.isOfs && (reqDec.sel == 2'(i));
    end

    for (genvar i = 0; i < CTR_NUM_GAIN; i++)
    begin : g_gain_hit
        assign gainHit[i] = accessWr && reqDec.isGain && (reqDec.sel == 2'(i));
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st;
        nxt_st.loaded = ldrDone && !fuseWr.valid;

        if (fuseWr.valid)
        begin
            if (!fuseWr.idx[2])
            begin
                nxt_st.ofs[fuseWr.idx[1:0]] = fuseWr.data;
            end
            else
            begin
                nxt_st.gain[fuseWr.idx[1:0]] = fuseWr.data[7:0];
            end
        end

        if (apbReq.psel)
        begin
            nxt_st.rdata = ctrReadWord(reqDec, st.ofs, st.gain);
            nxt_st.slverr = !(reqDec.isOfs || reqDec.isGain);
        end

        for (int i = 0; i < CTR_NUM_OFS; i++)
        begin
            if (ofsHit[i])
            begin
                nxt_st.ofs[i] = ctrMergeOfs(nxt_st.ofs[i], apbReq.pwdata,
                                            apbReq.pstrb);
            end
        end
        for (int i = 0; i < CTR_NUM_GAIN; i++)
        begin
            if (gainHit[i] && apbReq.pstrb[0])
            begin
                nxt_st.gain[i] = apbReq.pwdata[7:0];
            end
        end

        if (core3SampleFourth)
        begin
            nxt_st.trim.offsetCore3 = nxt_st.ofs[1][CTR_OFS_VAL_W-1:0];
        end
        else
        begin
            nxt_st.trim.offsetCore3 = nxt_st.ofs[0][CTR_OFS_VAL_W-1:0];
        end
        nxt_st.trim.offsetCore4 = nxt_st.ofs[2][CTR_OFS_VAL_W-1:0];
        nxt_st.trim.offsetCore5 = nxt_st.ofs[3][CTR_OFS_VAL_W-1:0];

        nxt_st.trim.gainCore0 = nxt_st.gain[0][CTR_GAIN_VAL_W-1:0];
        nxt_st.trim.gainCore1 = nxt_st.gain[1][CTR_GAIN_VAL_W-1:0];
        if (core2SampleSecond)
        begin
            nxt_st.trim.gainCore2 = nxt_st.gain[3][CTR_GAIN_VAL_W-1:0];
        end
        else
        begin
            nxt_st.trim.gainCore2 = nxt_st.gain[2][CTR_GAIN_VAL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '{ofs: {CTR_NUM_OFS{CTR_OFS_RESET}},
                    gain: {CTR_NUM_GAIN{CTR_GAIN_RESET}},
                    rdata: 32'h00000000,
                    slverr: 1'b0,
                    loaded: 1'b0,
                    trim: '0};
        end
        else
        begin
            st <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign apbRsp.pready = st.loaded;
    assign apbRsp.pslverr = st.slverr && apbReq.psel && apbReq.penable && st.loaded;
    assign apbRsp.prdata = st.rdata;
    assign trimOut = st.trim;
    assign loadDone = st.loaded;

endmodule : ctr_trim_bank

// file: tb/ctr_trim_bank_chk.sv
// Checker of the trim register bank ports.
`timescale 1ns/10ps
module ctr_trim_bank_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ctr_pkg::ctr_apb_req_t apbReq,
    input wire ctr_pkg::ctr_apb_rsp_t apbRsp,
    input wire logic core3SampleFourth,
    input wire logic core2SampleSecond,
    input wire ctr_pkg::ctr_trim_out_t trimOut,
    input wire logic loadDone
);
    import ctr_pkg::*;
    logic rdAcc;
    logic [11:0] adr;
    logic [31:0] rdat;
    assign rdAcc = apbReq.psel & apbReq.penable & apbRsp.pready & ~apbReq.pwrite;
    assign adr = apbReq.paddr;
    assign rdat = apbRsp.prdata;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    a_core3_third: assert property (
        rdAcc && adr == 12'hCE0 && !$past(core3SampleFourth)
        |-> trimOut.offsetCore3 == rdat[11:0]) else $error("core 3 third offset wrong");
    a_core3_fourth: assert property (
        rdAcc && adr == 12'hCE8 && $past(core3SampleFourth)
        |-> trimOut.offsetCore3 == rdat[11:0]) else $error("core 3 fourth offset wrong");
    a_core4_apply: assert property (rdAcc && adr == 12'hCF0
        |-> trimOut.offsetCore4 == rdat[11:0]) else $error("core 4 offset wrong");
    a_fine_gain_trim_core0_apply: assert property (rdAcc && adr == 12'hD80
        |-> trimOut.gainCore0 == rdat[4:0]) else $error("core 0 gain wrong");
    a_core2_first: assert property (
        rdAcc && adr == 12'hD88 && !$past(core2SampleSecond)
        |-> trimOut.gainCore2 == rdat[4:0]) else $error("core 2 first gain wrong");
    a_core2_second: assert property (
        rdAcc && adr == 12'hD8C && $past(core2SampleSecond)
        |-> trimOut.gainCore2 == rdat[4:0]) else $error("core 2 second gain wrong");
    a_bad_addr: assert property (
        apbReq.psel && apbReq.penable && apbRsp.pready && adr[1:0] != 2'h0
        |-> apbRsp.pslverr && rdat == 32'h0) else $error("misaligned access not refused");
    a_reset_zero: assert property (!$past(reset_n) |-> trimOut == '0 && !loadDone)
        else $error("trims not zero after reset");
    a_load_bound: assert property (!loadDone |-> ##[1:12] loadDone && apbRsp.pready)
        else $error("fuse load too slow");
endmodule : ctr_trim_bank_chk

bind ctr_trim_bank ctr_trim_bank_chk u_ctr_trim_bank_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .core3SampleFourth(core3SampleFourth),
    .core2SampleSecond(core2SampleSecond), .trimOut(trimOut), .loadDone(loadDone));

// file: tb/testbench.sv
// Self-checking testbench of the trim register bank.
`timescale 1ns/10ps
module testbench;
    import ctr_pkg::*;
    typedef struct packed {
        logic [3:0] idx;
        logic [31:0] wd;
        logic [3:0] st;
        logic [31:0] rd;
    } ctr_row_t;
    localparam logic [11:0] ADR [10] = '{12'hCE0, 12'hCE8, 12'hCF0, 12'hCF8, 12'hD80,
        12'hD84, 12'hD88, 12'hD8C, 12'hCE4, 12'hCE2};
    localparam ctr_row_t ROWS [11] = '{'{4'h0, 32'hABC, 4'hF, 32'hABC},
        '{4'h1, 32'hFFF, 4'hF, 32'hFFF}, '{4'h2, 32'h1, 4'hF, 32'h1},
        '{4'h3, 32'h800, 4'hF, 32'h800}, '{4'h4, 32'h1F, 4'hF, 32'h1F},
        '{4'h5, 32'h0, 4'hF, 32'h0}, '{4'h6, 32'h15, 4'hF, 32'h15},
        '{4'h7, 32'hA, 4'hF, 32'hA}, '{4'h2, 32'h355, 4'h1, 32'h55},
        '{4'h8, 32'h123, 4'hF, 32'h0}, '{4'h9, 32'h123, 4'hF, 32'h0}};
    logic ref_clk;
    logic reset_n;
    ctr_apb_req_t apbReq;
    ctr_apb_rsp_t apbRsp;
    logic core3SampleFourth;
    logic core2SampleSecond;
    logic fuseRdEn;
    logic [2:0] fuseAddr;
    logic [15:0] fuseData;
    ctr_trim_out_t trimOut;
    logic loadDone;
    int err_count;
    int cmp_count;
    logic [31:0] rd;
    logic er;

    ctr_trim_bank u_ctr_trim_bank (.ref_clk(ref_clk), .reset_n(reset_n), .apbReq(apbReq),
        .apbRsp(apbRsp), .core3SampleFourth(core3SampleFourth),
        .core2SampleSecond(core2SampleSecond), .fuseRdEn(fuseRdEn), .fuseAddr(fuseAddr),
        .fuseData(fuseData), .trimOut(trimOut), .loadDone(loadDone));

    function automatic logic [15:0] fuseWord(input logic [2:0] a);
        return {5'h0, a, 8'h10 + {5'h0, a}};
    endfunction : fuseWord

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Fuse storage answers one cycle after a read and scrambles when idle.
    always @(posedge ref_clk)
    begin
        fuseData <= fuseRdEn ? fuseWord(fuseAddr) : ~fuseData;
    end

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask : chk

    task automatic apb(input int i, input logic [31:0] d, input logic [3:0] s, input logic w);
        int n;
        apbReq <= '{1'b1, 1'b0, w, ADR[i], d, s};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 100);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge ref_clk);
        if (n >= 100)
        begin
            err_count++;
            final_report();
        end
    endtask : apb

    task automatic doReset;
        reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("reset", 64'({trimOut, apbRsp.pready, loadDone}), 64'h0);
        reset_n <= 1'b1;
    endtask : doReset

    initial
    begin
        reset_n = 1'b0;
        apbReq = '0;
        core3SampleFourth = 1'b0;
        core2SampleSecond = 1'b0;
        err_count = 0;
        cmp_count = 0;
        doReset();
        for (int i = 0; i < 8; i++)
        begin
            apb(i, 32'h0, 4'h0, 1'b0);
            chk("fuse", 64'({er, rd}),
                64'(fuseWord(3'(i)) & ((i < 4) ? 16'hFFFF : 16'h00FF)));
        end
        for (int r = 0; r < 11; r++)
        begin
            apb(ROWS[r].idx, ROWS[r].wd, ROWS[r].st, 1'b1);
            chk("wr_err", 64'(er), 64'(ROWS[r].idx > 4'h7));
            apb(ROWS[r].idx, 32'h0, 4'h0, 1'b0);
            chk("rd", 64'({er, rd}), 64'({ROWS[r].idx > 4'h7, ROWS[r].rd}));
        end
        chk("trim_a", 64'(trimOut),
            64'({12'hABC, 12'h55, 12'h800, 5'h1F, 5'h0, 5'h15}));
        core3SampleFourth <= 1'b1;
        core2SampleSecond <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("trim_b", 64'(trimOut),
            64'({12'hFFF, 12'h55, 12'h800, 5'h1F, 5'h0, 5'hA}));
        apb(1, 32'h0, 4'h0, 1'b0);
        chk("rd_fourth", 64'({er, rd}), 64'h0FFF);
        apb(7, 32'h0, 4'h0, 1'b0);
        chk("rd_second", 64'({er, rd}), 64'h000A);
        doReset();
        apb(0, 32'h0, 4'h0, 1'b0);
        chk("reload", 64'({er, rd}), 64'h10);
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        final_report();
    end
endmodule : testbench
